/* File: src/pirdly_pkg.sv */
// Shared constants for the pin interrupt router and message delivery block.
// Assumes a single 20 MHz clock and an asynchronous active-low reset.
package pirdly_pkg;
    localparam int NUM_PINS = 16;
    localparam int NUM_ENTRIES = 24;
    localparam int NUM_VIRTUAL = 7;
    localparam int FIRST_VIRTUAL_ENTRY = 16;
    localparam int HOT_PLUG_ENTRY = 23;
    localparam int IDX_W = 5;
    localparam int NUM_INTX = 4;
    localparam int SYNC_STAGES = 2;

    // Message address layout
    localparam logic [11:0] MSG_ADDR_PREFIX = 12'hFEE;
    localparam int ADDR_PREFIX_LSB = 20;
    localparam int ADDR_DEST_LSB = 12;
    localparam int ADDR_EXT_DEST_LSB = 4;
    localparam int ADDR_HINT_BIT = 3;
    localparam int ADDR_DEST_MODE_BIT = 2;

    // Message data layout
    localparam int DATA_TRIGGER_BIT = 15;
    localparam int DATA_LEVEL_BIT = 14;
    localparam int DATA_DEST_MODE_BIT = 11;
    localparam int DATA_DELIVERY_LSB = 8;
    localparam int DATA_VECTOR_LSB = 0;

    localparam logic [2:0] DELIVERY_LOWEST_PRIORITY = 3'h1;

    // Legacy wire lines
    localparam logic [1:0] INTX_A = 2'h0;
    localparam logic [1:0] INTX_B = 2'h1;

    // Values after reset
    localparam logic [NUM_ENTRIES-1:0] FLAGS_RESET = 24'h000000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    localparam logic [NUM_INTX-1:0] INTX_RESET = 4'h0;
    localparam logic [IDX_W-1:0] IDX_RESET = 5'h00;

    typedef enum logic [0:0] {
        DLV_IDLE,
        DLV_SEND
    } pirdly_dlv_state_t;
endpackage

/* File: src/pirdly_sync.sv */
// Two-flop level synchroniser, one bit per lane.
// Assumes the inputs are asynchronous to clk; only the second stage is read.
module pirdly_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Lanes
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle high like the pulled-up pins, so no false edge follows reset
            stage1 <= '1;
            sync_out <= '1;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* File: src/pirdly_msg_fmt.sv */
// Builds the upstream interrupt message address and data from one entry.
// Purely combinational; the caller registers the result before it leaves.
module pirdly_msg_fmt (
    // Entry fields
    input wire logic [7:0] dest_id,
    input wire logic [7:0] ext_dest_id,
    input wire logic [2:0] delivery_mode,
    input wire logic dest_mode,
    input wire logic trigger_level,
    input wire logic level_now,
    input wire logic [7:0] vector,
    // Formatted message
    output logic [31:0] msg_addr,
    output logic [31:0] msg_data
);
    logic hint;

    assign hint = (delivery_mode == pirdly_pkg::DELIVERY_LOWEST_PRIORITY);

    always_comb begin
        msg_addr = pirdly_pkg::WORD_RESET;
        msg_addr[31:pirdly_pkg::ADDR_PREFIX_LSB] = pirdly_pkg::MSG_ADDR_PREFIX;
        msg_addr[pirdly_pkg::ADDR_DEST_LSB +: 8] = dest_id;
        msg_addr[pirdly_pkg::ADDR_EXT_DEST_LSB +: 8] = ext_dest_id;
        msg_addr[pirdly_pkg::ADDR_HINT_BIT] = hint;
        // Logical-group targeting is decided upstream from hint and this bit together
        msg_addr[pirdly_pkg::ADDR_DEST_MODE_BIT] = dest_mode;

        msg_data = pirdly_pkg::WORD_RESET;
        msg_data[pirdly_pkg::DATA_TRIGGER_BIT] = trigger_level;
        msg_data[pirdly_pkg::DATA_LEVEL_BIT] = trigger_level ? level_now : 1'b1;
        msg_data[pirdly_pkg::DATA_DEST_MODE_BIT] = dest_mode;
        msg_data[pirdly_pkg::DATA_DELIVERY_LSB +: 3] = delivery_mode;
        msg_data[pirdly_pkg::DATA_VECTOR_LSB +: 8] = vector;
    end
endmodule

/* File: src/pirdly_top.sv */
// Pin interrupt router: redirection-entry scheduling, upstream message
// delivery, end-of-interrupt handling, legacy wire messages and MSI pass-through.
// Assumes entry configuration is held steady by its owner and that all
// inputs other than the pins come from logic on clk.
//
// Summary of operation
// - Sixteen pins, per-entry trigger mode and polarity.
// - Synchronise pins; schedule only unmasked entries.
// - Pins feed entries fifteen down to zero.
// - Hot-plug interrupt fixed to entry twenty-three.
// - Other entries driven only by virtual wires.
// - Forward in-window inbound MSI writes unchanged.
// - Masked pin and hot-plug entries make legacy messages, unmasked none.
// - Assert message on rising edge of OR.
// - Deassert message on falling edge of OR.
// - Fixed pin and hot-plug to legacy line routing.
// - Pin interrupts never flush inbound posted writes.
// - End-of-interrupt vector match clears remote pending.
// - Every matching entry is cleared, not just one.
// - End-of-interrupt is consumed, never sent downstream.
// - Set request flag yields one upstream message write.
// - Address top bits FEE, bottom two zero.
// - Address destination from entry bits sixty-three down.
// - Address extended destination from entry bits fifty-five.
// - Redirection hint set for lowest-priority delivery.
// - Address bit two carries destination mode.
// - Data zero fields, trigger and destination mode bits.
// - Level bit one for edge, input level otherwise.
// - Data carries delivery mode and vector.
module pirdly_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Interrupt sources
    input wire logic [15:0] pci_side_irq_pins_n,
    input wire logic hot_plug_irq_a,
    input wire logic hot_plug_irq_b,
    input wire logic [6:0] virtual_wire_level,
    input wire logic [3:0] other_side_intx_level,
    // Redirection entry configuration, one lane per entry
    input wire logic [23:0] entry_mask,
    input wire logic [23:0] entry_trigger_level,
    input wire logic [23:0] entry_active_low,
    input wire logic [23:0] entry_dest_mode,
    input wire logic [191:0] entry_vector,
    input wire logic [71:0] entry_delivery_mode,
    input wire logic [191:0] entry_dest_id,
    input wire logic [191:0] entry_ext_dest_id,
    // Entry status
    output logic [23:0] delivery_request_flag,
    output logic [23:0] remote_pending_flag,
    // Upstream interrupt message write
    output logic msg_valid,
    input wire logic msg_ready,
    output logic [31:0] msg_addr,
    output logic [31:0] msg_data,
    // End-of-interrupt broadcast from upstream
    input wire logic eoi_valid,
    input wire logic [7:0] eoi_vector,
    // Legacy wire messages upstream
    output logic intx_valid,
    input wire logic intx_ready,
    output logic [1:0] intx_line,
    output logic intx_assert,
    // Inbound MSI writes from PCI and their upstream forward
    input wire logic msi_in_valid,
    output logic msi_in_ready,
    input wire logic msi_in_window,
    input wire logic [31:0] msi_in_addr,
    input wire logic [31:0] msi_in_data,
    output logic msi_out_valid,
    input wire logic msi_out_ready,
    output logic [31:0] msi_out_addr,
    output logic [31:0] msi_out_data
);
    localparam int N = pirdly_pkg::NUM_ENTRIES;

    logic [15:0] pins_sync;
    logic [N-1:0] src_level;
    logic [N-1:0] active;
    logic [N-1:0] active_prev;
    logic [N-1:0] next_request;
    logic [N-1:0] next_remote;
    logic [N-1:0] eoi_match;
    logic [N-1:0] grant_clear;
    logic [N-1:0] grant_remote_set;
    pirdly_pkg::pirdly_dlv_state_t state;

    // Synchronise the external pins before anything looks at them
    pirdly_sync #(
        .WIDTH(pirdly_pkg::NUM_PINS)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pci_side_irq_pins_n),
        .sync_out(pins_sync)
    );

    // Source of each entry: pins, virtual wires, hot-plug
    always_comb begin
        src_level = pirdly_pkg::FLAGS_RESET;
        src_level[15:0] = pins_sync;
        src_level[22:16] = virtual_wire_level;
        src_level[pirdly_pkg::HOT_PLUG_ENTRY] = hot_plug_irq_a;
    end

    // Polarity per entry turns the raw level into an asserted level
    assign active = src_level ^ entry_active_low;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_prev <= pirdly_pkg::FLAGS_RESET;
        end else begin
            active_prev <= active;
        end
    end

    // Request flags: an edge set wins over the grant clear; a level set does not
    always_comb begin
        next_request = delivery_request_flag;
        for (int i = 0; i < N; i++) begin
            if (grant_clear[i]) begin
                next_request[i] = 1'b0;
            end
            if (entry_trigger_level[i] && !active[i]) begin
                // A level that went away before delivery is no longer owed
                next_request[i] = 1'b0;
            end
            if (!entry_mask[i]) begin
                if (entry_trigger_level[i]) begin
                    if (active[i] && !remote_pending_flag[i] && !grant_remote_set[i]) begin
                        next_request[i] = 1'b1;
                    end
                end else if (active[i] && !active_prev[i]) begin
                    next_request[i] = 1'b1;
                end
            end else if (!grant_clear[i]) begin
                next_request[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            delivery_request_flag <= pirdly_pkg::FLAGS_RESET;
        end else begin
            delivery_request_flag <= next_request;
        end
    end

    // End-of-interrupt compares against every entry at once
    always_comb begin
        eoi_match = pirdly_pkg::FLAGS_RESET;
        for (int i = 0; i < N; i++) begin
            eoi_match[i] = eoi_valid && (entry_vector[i*8 +: 8] == eoi_vector);
        end
    end

    // Remote pending: the delivery set wins over an EOI in the same cycle
    always_comb begin
        next_remote = remote_pending_flag;
        for (int i = 0; i < N; i++) begin
            if (eoi_match[i]) begin
                next_remote[i] = 1'b0;
            end
            if (grant_remote_set[i]) begin
                next_remote[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_pending_flag <= pirdly_pkg::FLAGS_RESET;
        end else begin
            remote_pending_flag <= next_remote;
        end
    end
    // The EOI has no path toward PCI; it ends here

    // Delivery: lowest-numbered pending entry goes first
    logic any_req;
    logic [pirdly_pkg::IDX_W-1:0] pick;
    logic [pirdly_pkg::IDX_W-1:0] sel;
    logic [31:0] fmt_addr;
    logic [31:0] fmt_data;
    logic sel_level;

    always_comb begin
        any_req = 1'b0;
        pick = pirdly_pkg::IDX_RESET;
        for (int i = N - 1; i >= 0; i--) begin
            if (delivery_request_flag[i]) begin
                any_req = 1'b1;
                pick = pirdly_pkg::IDX_W'(i);
            end
        end
    end

    pirdly_msg_fmt u_fmt (
        .dest_id(entry_dest_id[pick*8 +: 8]),
        .ext_dest_id(entry_ext_dest_id[pick*8 +: 8]),
        .delivery_mode(entry_delivery_mode[pick*3 +: 3]),
        .dest_mode(entry_dest_mode[pick]),
        .trigger_level(entry_trigger_level[pick]),
        .level_now(active[pick]),
        .vector(entry_vector[pick*8 +: 8]),
        .msg_addr(fmt_addr),
        .msg_data(fmt_data)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= pirdly_pkg::DLV_IDLE;
            sel <= pirdly_pkg::IDX_RESET;
            sel_level <= 1'b0;
            msg_addr <= pirdly_pkg::WORD_RESET;
            msg_data <= pirdly_pkg::WORD_RESET;
        end else begin
            case (state)
                pirdly_pkg::DLV_IDLE: begin
                    if (any_req) begin
                        sel <= pick;
                        sel_level <= entry_trigger_level[pick];
                        msg_addr <= fmt_addr;
                        msg_data <= fmt_data;
                        state <= pirdly_pkg::DLV_SEND;
                    end
                end
                pirdly_pkg::DLV_SEND: begin
                    if (msg_ready) begin
                        state <= pirdly_pkg::DLV_IDLE;
                    end
                end
                default: begin
                    state <= pirdly_pkg::DLV_IDLE;
                end
            endcase
        end
    end

    assign msg_valid = (state == pirdly_pkg::DLV_SEND);

    // One write per set flag: the flag drops as the write is taken
    always_comb begin
        grant_clear = pirdly_pkg::FLAGS_RESET;
        grant_remote_set = pirdly_pkg::FLAGS_RESET;
        if (msg_valid && msg_ready) begin
            grant_clear[sel] = 1'b1;
            grant_remote_set[sel] = sel_level;
        end
    end

    // Legacy wire lines from masked pin and hot-plug entries, the second hot-plug source and other-side levels
    logic [3:0] intx_level;
    logic [3:0] intx_sent;
    logic [3:0] intx_diff;
    logic [1:0] intx_pick;

    always_comb begin
        intx_level = other_side_intx_level;
        for (int p = 0; p < pirdly_pkg::NUM_PINS; p++) begin
            intx_level[p % 4] = intx_level[p % 4] | (entry_mask[p] & active[p]);
        end
        intx_level[pirdly_pkg::INTX_A] = intx_level[pirdly_pkg::INTX_A]
            | (entry_mask[pirdly_pkg::HOT_PLUG_ENTRY] & active[pirdly_pkg::HOT_PLUG_ENTRY]);
        // The second hot-plug source has no entry, so it is treated as masked
        intx_level[pirdly_pkg::INTX_B] = intx_level[pirdly_pkg::INTX_B] | hot_plug_irq_b;
    end

    // A line whose reported state lags its level owes a message
    assign intx_diff = intx_level ^ intx_sent;

    always_comb begin
        intx_pick = 2'h0;
        for (int l = pirdly_pkg::NUM_INTX - 1; l >= 0; l--) begin
            if (intx_diff[l]) begin
                intx_pick = 2'(l);
            end
        end
    end

    // Glitches shorter than one handshake collapse, keeping the upstream pair balanced
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intx_valid <= 1'b0;
            intx_line <= 2'h0;
            intx_assert <= 1'b0;
            intx_sent <= pirdly_pkg::INTX_RESET;
        end else if (intx_valid) begin
            if (intx_ready) begin
                intx_valid <= 1'b0;
                intx_sent[intx_line] <= intx_assert;
            end
        end else if (|intx_diff) begin
            intx_valid <= 1'b1;
            intx_line <= intx_pick;
            intx_assert <= intx_level[intx_pick];
        end
    end

    // MSI pass-through: one register stage, address and data untouched
    assign msi_in_ready = !msi_out_valid || msi_out_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msi_out_valid <= 1'b0;
            msi_out_addr <= pirdly_pkg::WORD_RESET;
            msi_out_data <= pirdly_pkg::WORD_RESET;
        end else if (msi_in_ready) begin
            // Writes outside the window are accepted and dropped here; they belong elsewhere
            msi_out_valid <= msi_in_valid && msi_in_window;
            if (msi_in_valid && msi_in_window) begin
                msi_out_addr <= msi_in_addr;
                msi_out_data <= msi_in_data;
            end
        end
    end
    // Interrupts never wait on inbound posted writes; drivers order them
endmodule

/* File: bench/pirdly_sva.sv */
// Checker for the message, end-of-interrupt and pass-through ports.
// Bound to pirdly_top; sees only its ports.
module pirdly_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Entry state
    input wire logic [191:0] entry_vector,
    input wire logic [23:0] remote_pending_flag,
    // Message write
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire logic [31:0] msg_addr,
    input wire logic [31:0] msg_data,
    // End of interrupt
    input wire logic eoi_valid,
    input wire logic [7:0] eoi_vector,
    // Pass-through
    input wire logic msi_in_valid,
    input wire logic msi_in_ready,
    input wire logic msi_in_window,
    input wire logic [31:0] msi_in_addr,
    input wire logic [31:0] msi_in_data,
    input wire logic msi_out_valid,
    input wire logic [31:0] msi_out_addr,
    input wire logic [31:0] msi_out_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] eoi_hit;
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            eoi_hit[i] = entry_vector[i*8+:8] == eoi_vector;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_addr_fixed_bits: assert property (msg_valid |-> msg_addr[31:20] == 12'hFEE && msg_addr[1:0] == 2'h0)
        else $error("message address fixed bits wrong");
    a_data_zero_bits: assert property (msg_valid |-> msg_data[31:16] == 16'h0000 && msg_data[13:12] == 2'h0)
        else $error("message data zero fields wrong");
    a_redir_hint: assert property (msg_valid |-> msg_addr[3] == (msg_data[10:8] == 3'h1))
        else $error("redirection hint wrong");
    a_dest_mode_copy: assert property (msg_valid |-> msg_addr[2] == msg_data[11])
        else $error("destination mode differs");
    a_edge_level_bit: assert property (msg_valid && !msg_data[15] |-> msg_data[14])
        else $error("edge message level bit low");
    a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr) && $stable(msg_data))
        else $error("message dropped or changed before ready");
    a_msi_forward: assert property (msi_in_valid && msi_in_ready && msi_in_window |=>
        msi_out_valid && msi_out_addr == $past(msi_in_addr) && msi_out_data == $past(msi_in_data))
        else $error("pass-through write altered");
    a_eoi_clears: assert property (eoi_valid && !(msg_valid && msg_ready) |=>
        (remote_pending_flag & $past(eoi_hit)) == 24'h000000)
        else $error("matching pending flag not cleared");
endmodule

bind pirdly_top pirdly_sva u_sva (.clk, .rst_n, .entry_vector, .remote_pending_flag, .msg_valid, .msg_ready,
    .msg_addr, .msg_data, .eoi_valid, .eoi_vector, .msi_in_valid, .msi_in_ready, .msi_in_window, .msi_in_addr,
    .msi_in_data, .msi_out_valid, .msi_out_addr, .msi_out_data);

/* File: bench/pirdly_host_model.sv */
// Upstream host: accepts message, legacy and forwarded writes.
// Slow mode grants each path one cycle in four, staggered.
module pirdly_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pace
    input wire logic slow,
    // Grants
    output logic msg_ready,
    output logic intx_ready,
    output logic msi_out_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 2'h0;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
    // Ready moves only just after an edge since cnt is registered
    assign msg_ready = !slow || cnt == 2'h0;
    assign intx_ready = !slow || cnt == 2'h1;
    assign msi_out_ready = !slow || cnt == 2'h2;
endmodule

/* File: bench/test_pin_interrupt_router_delivery.sv */
// Self-checking bench for pirdly_top with the host model.
// Assumes a 50 ns clock; inputs change by NBA at rising edges.
module test_pin_interrupt_router_delivery;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, hot_plug_irq_a, hot_plug_irq_b, msg_ready, eoi_valid, intx_ready, slow;
    logic msi_in_valid, msi_in_window, msi_out_ready, msg_valid, intx_valid, intx_assert, msi_in_ready;
    logic msi_out_valid;
    logic [1:0] intx_line;
    logic [3:0] other_side_intx_level;
    logic [6:0] virtual_wire_level;
    logic [7:0] eoi_vector;
    logic [15:0] pci_side_irq_pins_n;
    logic [23:0] entry_mask, entry_trigger_level, entry_active_low, entry_dest_mode;
    logic [23:0] delivery_request_flag, remote_pending_flag;
    logic [71:0] entry_delivery_mode;
    logic [191:0] entry_vector, entry_dest_id, entry_ext_dest_id;
    logic [31:0] msg_addr, msg_data, msi_in_addr, msi_in_data, msi_out_addr, msi_out_data;
    int miscompares = 0;
    int checks_done = 0;
    pirdly_top DUT (.clk, .rst_n, .pci_side_irq_pins_n, .hot_plug_irq_a, .hot_plug_irq_b, .virtual_wire_level,
        .other_side_intx_level, .entry_mask, .entry_trigger_level, .entry_active_low, .entry_dest_mode,
        .entry_vector, .entry_delivery_mode, .entry_dest_id, .entry_ext_dest_id, .delivery_request_flag,
        .remote_pending_flag, .msg_valid, .msg_ready, .msg_addr, .msg_data, .eoi_valid, .eoi_vector, .intx_valid,
        .intx_ready, .intx_line, .intx_assert, .msi_in_valid, .msi_in_ready, .msi_in_window, .msi_in_addr,
        .msi_in_data, .msi_out_valid, .msi_out_ready, .msi_out_addr, .msi_out_data);
    pirdly_host_model u_host (.clk, .rst_n, .slow, .msg_ready, .intx_ready, .msi_out_ready);
    always #25 clk = ~clk;
    function automatic logic [31:0] ea(int i);
        return {12'hFEE, entry_dest_id[i*8+:8], entry_ext_dest_id[i*8+:8],
            entry_delivery_mode[i*3+:3] == 3'h1, entry_dest_mode[i], 2'h0};
    endfunction
    function automatic logic [31:0] ed(int i);
        return {16'h0000, entry_trigger_level[i], 1'b1, 2'h0, entry_dest_mode[i],
            entry_delivery_mode[i*3+:3], entry_vector[i*8+:8]};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            miscompares++;
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk);
            check({msg_valid, intx_valid, msi_out_valid}, 64'h0);
        end
    endtask
    // Waits for a handshake on one of three paths and samples it at mid-cycle
    task automatic wait_hs(input int k);
        int n;
        n = 0;
        @(negedge clk);
        while (n < 100 && !(k == 0 ? msg_valid && msg_ready : k == 1 ? intx_valid && intx_ready
                : msi_out_valid && msi_out_ready)) begin
            @(negedge clk);
            n++;
        end
        check(n < 100, 1);
    endtask
    task automatic get_msg(input int i);
        wait_hs(0);
        check({msg_addr, msg_data}, {ea(i), ed(i)});
        @(posedge clk);
    endtask
    task automatic get_intx(input int l, input logic a);
        wait_hs(1);
        check({intx_line, intx_assert}, {l[1:0], a});
        @(posedge clk);
    endtask
    task automatic eoi(input logic [7:0] v);
        @(posedge clk);
        eoi_valid <= 1'b1;
        eoi_vector <= v;
        @(posedge clk);
        eoi_valid <= 1'b0;
    endtask
    task automatic send_msi(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        {msi_in_valid, msi_in_window, msi_in_addr, msi_in_data} <= {1'b1, w, a, d};
        do @(negedge clk); while (msi_in_ready !== 1'b1);
        @(posedge clk);
        msi_in_valid <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
    initial begin
        {clk, rst_n, hot_plug_irq_a, hot_plug_irq_b, eoi_valid, msi_in_valid, msi_in_window, slow} = 8'h00;
        {other_side_intx_level, virtual_wire_level, eoi_vector, msi_in_addr, msi_in_data} = 83'h0;
        pci_side_irq_pins_n = 16'hFFFF;
        entry_mask = 24'hFFFFFF;
        entry_trigger_level = 24'h000000;
        entry_active_low = 24'h00FFFF;
        entry_dest_mode = 24'hA5A5A5;
        // Entry 16 shares the vector of entry 23
        for (int i = 0; i < 24; i++) begin
            entry_vector[i*8+:8] = (i == 16) ? 8'h57 : 8'(8'h40 + i);
            entry_dest_id[i*8+:8] = 8'(8'h80 + i);
            entry_ext_dest_id[i*8+:8] = 8'(8'hC3 ^ i);
            entry_delivery_mode[i*3+:3] = 3'(i);
        end
        repeat (11) @(posedge clk);
        @(negedge clk);
        check({remote_pending_flag, delivery_request_flag, msg_valid, intx_valid, msi_out_valid, msi_in_ready}, 1);
        @(posedge clk);
        rst_n <= 1'b1;
        quiet(4);
        @(posedge clk);
        entry_mask[15:0] <= 16'h0000;
        for (int p = 0; p < 16; p++) begin
            @(posedge clk);
            slow <= p[0];
            pci_side_irq_pins_n[p] <= 1'b0;
            get_msg(p);
            quiet(6);
            @(posedge clk);
            pci_side_irq_pins_n[p] <= 1'b1;
            quiet(4);
        end
        @(posedge clk);
        {entry_mask[23], entry_mask[16], entry_trigger_level[23], entry_trigger_level[16]} <= 4'h3;
        @(posedge clk);
        {hot_plug_irq_a, virtual_wire_level[0]} <= 2'h3;
        get_msg(16);
        get_msg(23);
        quiet(6);
        check(remote_pending_flag, 24'h810000);
        eoi(8'h40);
        quiet(2);
        check(remote_pending_flag, 24'h810000);
        @(posedge clk);
        {hot_plug_irq_a, virtual_wire_level[0]} <= 2'h0;
        eoi(8'h57);
        quiet(3);
        check(remote_pending_flag, 24'h000000);
        send_msi(1'b1, 32'hFEE01234, 32'h0000ABCD);
        wait_hs(2);
        check({msi_out_addr, msi_out_data}, 64'hFEE012340000ABCD);
        @(posedge clk);
        send_msi(1'b0, 32'h12345678, 32'h00000042);
        quiet(4);
        @(posedge clk);
        entry_mask <= 24'hFFFFFF;
        for (int p = 0; p < 16; p++) begin
            @(posedge clk);
            slow <= p[0];
            pci_side_irq_pins_n[p] <= 1'b0;
            get_intx(p % 4, 1'b1);
            quiet(3);
            @(posedge clk);
            pci_side_irq_pins_n[p] <= 1'b1;
            get_intx(p % 4, 1'b0);
        end
        @(posedge clk);
        pci_side_irq_pins_n[2] <= 1'b0;
        get_intx(2, 1'b1);
        pci_side_irq_pins_n[6] <= 1'b0;
        quiet(5);
        @(posedge clk);
        pci_side_irq_pins_n[2] <= 1'b1;
        quiet(5);
        @(posedge clk);
        pci_side_irq_pins_n[6] <= 1'b1;
        get_intx(2, 1'b0);
        hot_plug_irq_b <= 1'b1;
        get_intx(1, 1'b1);
        other_side_intx_level[3] <= 1'b1;
        get_intx(3, 1'b1);
        hot_plug_irq_a <= 1'b1;
        get_intx(0, 1'b1);
        {hot_plug_irq_a, hot_plug_irq_b, other_side_intx_level[3]} <= 3'h0;
        get_intx(0, 1'b0);
        get_intx(1, 1'b0);
        get_intx(3, 1'b0);
        quiet(4);
        final_report();
    end
endmodule
